/* File: hlm_pkg.sv */
/*
 * Shared constants and carrier types for the host halfword lane mapper.
 * Assumes a single 250 MHz device clock and an SRAM-like host bus whose
 * byte address bits 7:1 reach the device.
 */
package hlm_pkg;

    localparam int unsigned CLK_MHZ = 250;
    localparam logic [7:0] HLM_WSWAP_OFS = 8'h98;
    localparam logic [31:0] HLM_WSWAP_RST = 32'h00000000;
    localparam logic [31:0] HLM_WSWAP_ON = 32'hFFFFFFFF;
    localparam logic [1:0] HLM_HW_LOW = 2'h1;
    localparam logic [1:0] HLM_HW_HIGH = 2'h2;
    localparam logic [1:0] HLM_HW_BOTH = 2'h3;
    localparam int unsigned HLM_HALF = 16;

    // Host pins after synchronisation; strobes are active high here.
    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic bus16;
        logic [7:1] addr;
        logic [31:0] data;
    } hlm_pins_type;

    // One access to the internal registers and data FIFOs.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:2] widx;
        logic [1:0] hw_en;
        logic [31:0] wdata;
    } hlm_req_type;

endpackage : hlm_pkg

/* File: hlm_net_lanes.sv */
/*
 * Network-side halfword lanes: splits transmit FIFO words into halfwords
 * and packs received halfwords into receive FIFO words.
 * Assumes the receive FIFO always accepts a packed word.
 */
`timescale 1ns/100ps

module hlm_net_lanes
    import hlm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Transmit FIFO side
    input wire logic tx_word_valid_i,
    input wire logic [31:0] tx_word_i,
    output logic tx_word_ready_o,
    // Network transmit halfwords
    output logic tx_hw_valid_o,
    output logic [15:0] tx_hw_o,
    input wire logic tx_hw_ready_i,
    // Network receive halfwords
    input wire logic rx_hw_valid_i,
    input wire logic [15:0] rx_hw_i,
    // Receive FIFO side
    output logic rx_word_valid_o,
    output logic [31:0] rx_word_o
);

    typedef enum logic [1:0] {TX_IDLE, TX_LOW, TX_HIGH} hlm_tx_state_type;

    hlm_tx_state_type tx_st_ff, nxt_tx_st;
    logic [15:0] tx_hi_ff, nxt_tx_hi;
    logic [15:0] tx_hw_ff, nxt_tx_hw;
    logic rx_half_ff, nxt_rx_half;
    logic [15:0] rx_lo_ff, nxt_rx_lo;
    logic rx_valid_ff, nxt_rx_valid;
    logic [31:0] rx_word_ff, nxt_rx_word;
    logic tx_rdy_ff, nxt_tx_rdy;
    logic tx_vld_ff, nxt_tx_vld;

    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_hi = tx_hi_ff;
        nxt_tx_hw = tx_hw_ff;
        case (tx_st_ff)
            TX_IDLE: begin
                if (tx_word_valid_i) begin
                    nxt_tx_hw = tx_word_i[HLM_HALF-1:0];
                    nxt_tx_hi = tx_word_i[31:HLM_HALF];
                    nxt_tx_st = TX_LOW;
                end
            end
            TX_LOW: begin
                if (tx_hw_ready_i) begin
                    nxt_tx_hw = tx_hi_ff;
                    nxt_tx_st = TX_HIGH;
                end
            end
            TX_HIGH: begin
                if (tx_hw_ready_i) begin
                    nxt_tx_st = TX_IDLE;
                end
            end
            default: nxt_tx_st = TX_IDLE;
        endcase
        // The flags follow the next state, so both leave the block from flops.
        nxt_tx_rdy = (nxt_tx_st == TX_IDLE);
        nxt_tx_vld = (nxt_tx_st != TX_IDLE);
    end

    always_comb begin
        nxt_rx_half = rx_half_ff;
        nxt_rx_lo = rx_lo_ff;
        nxt_rx_valid = 1'b0;
        nxt_rx_word = rx_word_ff;
        if (rx_hw_valid_i) begin
            if (!rx_half_ff) begin
                nxt_rx_lo = rx_hw_i;
                nxt_rx_half = 1'b1;
            end else begin
                nxt_rx_word = {rx_hw_i, rx_lo_ff};
                nxt_rx_valid = 1'b1;
                nxt_rx_half = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_st_ff <= TX_IDLE;
            tx_hi_ff <= '0;
            tx_hw_ff <= '0;
            rx_half_ff <= 1'b0;
            rx_lo_ff <= '0;
            rx_valid_ff <= 1'b0;
            rx_word_ff <= '0;
            tx_rdy_ff <= 1'b1;
            tx_vld_ff <= 1'b0;
        end else begin
            tx_st_ff <= nxt_tx_st;
            tx_hi_ff <= nxt_tx_hi;
            tx_hw_ff <= nxt_tx_hw;
            rx_half_ff <= nxt_rx_half;
            rx_lo_ff <= nxt_rx_lo;
            rx_valid_ff <= nxt_rx_valid;
            rx_word_ff <= nxt_rx_word;
            tx_rdy_ff <= nxt_tx_rdy;
            tx_vld_ff <= nxt_tx_vld;
        end
    end

    assign tx_word_ready_o = tx_rdy_ff;
    assign tx_hw_valid_o = tx_vld_ff;
    assign tx_hw_o = tx_hw_ff;
    assign rx_word_valid_o = rx_valid_ff;
    assign rx_word_o = rx_word_ff;

endmodule : hlm_net_lanes

/* File: hlm_lane_mapper.sv */
/*
 * Host halfword lane mapper: host bus slave that maps host data lanes onto
 * internal 32-bit registers and FIFO words, holds the halfword order
 * control register and carries the network halfword lanes.
 * Assumes internal read data is valid one cycle after the read pulse.
 */
// Functional notes
// - Halfword order control matters only in 16-bit mode.
// - 32-bit mode maps high lines high, low low.
// - Non-all-ones value: A1 high selects high half.
// - All-ones value: A1 high selects low half.
// - Transmit data leaves low halfword first.
// - Receive data enters low halfword first.
// - Mixed endian combines with halfword order.
`timescale 1ns/100ps

module hlm_lane_mapper
    import hlm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Host bus pins
    input wire logic cs_b_i,
    input wire logic rd_b_i,
    input wire logic wr_b_i,
    input wire logic bus16_i,
    input wire logic [7:1] haddr_i,
    input wire logic [31:0] hdata_i,
    output logic [31:0] hdata_o,
    output logic hdata_oe_o,
    // Endian setting from the configuration logic
    input wire logic mixed_endian_i,
    // Internal register and FIFO port
    output hlm_req_type int_req_o,
    input wire logic [31:0] int_rdata_i,
    // Transmit FIFO side
    input wire logic tx_word_valid_i,
    input wire logic [31:0] tx_word_i,
    output logic tx_word_ready_o,
    // Network transmit halfwords
    output logic tx_hw_valid_o,
    output logic [15:0] tx_hw_o,
    input wire logic tx_hw_ready_i,
    // Network receive halfwords
    input wire logic rx_hw_valid_i,
    input wire logic [15:0] rx_hw_i,
    // Receive FIFO side
    output logic rx_word_valid_o,
    output logic [31:0] rx_word_o,
    // Current halfword order control value
    output logic [31:0] wswap_o
);

    typedef enum logic [1:0] {H_IDLE, H_RD_REQ, H_RD_DATA, H_HOLD} hlm_host_state_type;

    hlm_pins_type sync1_ff, sync2_ff, pins_raw;
    hlm_host_state_type st_ff, nxt_st;
    hlm_req_type req_ff, nxt_req;
    logic [31:0] wswap_ff, nxt_wswap;
    logic [31:0] hdata_ff, nxt_hdata;
    logic oe_ff, nxt_oe;
    logic hi_ff, nxt_hi;
    logic loc_ff, nxt_loc;
    logic me_ff, nxt_me;
    logic b16_ff, nxt_b16;
    logic sel_hi;
    logic is_wswap;
    logic [1:0] hw_en;
    logic [31:0] wword;
    logic [31:0] rword;
    logic [31:0] src;
    logic [1:0] wswap_wr;
    logic [31:0] wswap_upd;

    function automatic logic [31:0] byte_rev(input logic [31:0] w);
        byte_rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : byte_rev

    assign pins_raw = '{sel: ~cs_b_i, rd: ~rd_b_i, wr: ~wr_b_i, bus16: bus16_i,
                        addr: haddr_i, data: hdata_i};

    // Pins are asynchronous to the device clock, so all pass two flops.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    // The register is read live, so a completed write steers the next access.
    assign sel_hi = sync2_ff.addr[1] ^ (wswap_ff == HLM_WSWAP_ON);
    assign is_wswap = ({sync2_ff.addr[7:2], 2'h0} == HLM_WSWAP_OFS);

    // Only a write taken in idle touches the control register lanes.
    assign wswap_wr = (st_ff == H_IDLE && sync2_ff.sel && sync2_ff.wr && is_wswap) ?
                      hw_en : 2'h0;

    // Each lane takes only its own halfword, so a narrow host builds the all-ones
    // value in two writes; a half-built value still leaves the order unswapped.
    for (genvar g = 0; g < 2; g++) begin : g_wswap_lane
        assign wswap_upd[g*HLM_HALF +: HLM_HALF] = wswap_wr[g] ?
            wword[g*HLM_HALF +: HLM_HALF] : wswap_ff[g*HLM_HALF +: HLM_HALF];
    end

    always_comb begin
        if (sync2_ff.bus16) begin
            wword = {sync2_ff.data[15:0], sync2_ff.data[15:0]};
            hw_en = sel_hi ? HLM_HW_HIGH : HLM_HW_LOW;
        end else begin
            wword = sync2_ff.data;
            hw_en = HLM_HW_BOTH;
        end
        // Swapping the enables keeps a narrow write on the lane its bytes now occupy.
        if (mixed_endian_i) begin
            wword = byte_rev(wword);
            hw_en = {hw_en[0], hw_en[1]};
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_req = req_ff;
        nxt_req.rd = 1'b0;
        nxt_req.wr = 1'b0;
        nxt_wswap = wswap_upd;
        nxt_hdata = hdata_ff;
        nxt_oe = oe_ff;
        nxt_hi = hi_ff;
        nxt_loc = loc_ff;
        nxt_me = me_ff;
        nxt_b16 = b16_ff;
        src = loc_ff ? wswap_ff : int_rdata_i;
        rword = me_ff ? byte_rev(src) : src;
        case (st_ff)
            H_IDLE: begin
                if (sync2_ff.sel && sync2_ff.wr) begin
                    nxt_st = H_HOLD;
                    // The control register lanes are written by g_wswap_lane.
                    if (!is_wswap) begin
                        nxt_req = '{rd: 1'b0, wr: 1'b1, widx: sync2_ff.addr[7:2],
                                    hw_en: hw_en, wdata: wword};
                    end
                end else if (sync2_ff.sel && sync2_ff.rd) begin
                    nxt_st = H_RD_REQ;
                    nxt_hi = hw_en[1] & ~hw_en[0];
                    nxt_me = mixed_endian_i;
                    nxt_b16 = sync2_ff.bus16;
                    nxt_loc = is_wswap;
                    nxt_req = '{rd: ~is_wswap, wr: 1'b0, widx: sync2_ff.addr[7:2],
                                hw_en: hw_en, wdata: req_ff.wdata};
                end
            end
            H_RD_REQ: nxt_st = H_RD_DATA;
            H_RD_DATA: begin
                if (!b16_ff) begin
                    nxt_hdata = rword;
                end else begin
                    // After the byte reversal the selected half sits mirrored.
                    nxt_hdata = {16'h0000, (hi_ff ^ me_ff) ? rword[31:16] : rword[15:0]};
                end
                nxt_oe = 1'b1;
                nxt_st = H_HOLD;
            end
            H_HOLD: begin
                // Waiting for the release keeps one long strobe from being
                // taken as a second access.
                if (!(sync2_ff.sel && (sync2_ff.rd || sync2_ff.wr))) begin
                    nxt_oe = 1'b0;
                    nxt_st = H_IDLE;
                end
            end
            default: nxt_st = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= H_IDLE;
            req_ff <= '0;
            wswap_ff <= HLM_WSWAP_RST;
            hdata_ff <= '0;
            oe_ff <= 1'b0;
            hi_ff <= 1'b0;
            loc_ff <= 1'b0;
            me_ff <= 1'b0;
            b16_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            req_ff <= nxt_req;
            wswap_ff <= nxt_wswap;
            hdata_ff <= nxt_hdata;
            oe_ff <= nxt_oe;
            hi_ff <= nxt_hi;
            loc_ff <= nxt_loc;
            me_ff <= nxt_me;
            b16_ff <= nxt_b16;
        end
    end

    assign int_req_o = req_ff;
    assign hdata_o = hdata_ff;
    assign hdata_oe_o = oe_ff;
    assign wswap_o = wswap_ff;

    hlm_net_lanes u_hlm_net_lanes (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tx_word_valid_i(tx_word_valid_i),
        .tx_word_i(tx_word_i),
        .tx_word_ready_o(tx_word_ready_o),
        .tx_hw_valid_o(tx_hw_valid_o),
        .tx_hw_o(tx_hw_o),
        .tx_hw_ready_i(tx_hw_ready_i),
        .rx_hw_valid_i(rx_hw_valid_i),
        .rx_hw_i(rx_hw_i),
        .rx_word_valid_o(rx_word_valid_o),
        .rx_word_o(rx_word_o)
    );

endmodule : hlm_lane_mapper

/* File: hlm_lane_mapper_properties.sv */
/* Port checker for the host halfword lane mapper.
   Assumes one clock, an active-low reset and host pins held through each access. */
`timescale 1ns/100ps
module hlm_lane_mapper_properties
    import hlm_pkg::*;
(
    // Clock, reset and host side
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic bus16_i,
    input wire logic [7:1] haddr_i,
    input wire logic [31:0] hdata_i,
    input wire logic [31:0] hdata_o,
    input wire logic hdata_oe_o,
    input wire logic mixed_endian_i,
    input wire logic [31:0] wswap_o,
    // Internal port
    input wire hlm_req_type int_req_o,
    input wire logic [31:0] int_rdata_i,
    // Network lanes
    input wire logic tx_word_valid_i,
    input wire logic [31:0] tx_word_i,
    input wire logic tx_word_ready_o,
    input wire logic tx_hw_valid_o,
    input wire logic [15:0] tx_hw_o,
    input wire logic tx_hw_ready_i,
    input wire logic rx_hw_valid_i,
    input wire logic [15:0] rx_hw_i,
    input wire logic rx_word_valid_o,
    input wire logic [31:0] rx_word_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [31:0] tx_w_ff;
    logic [15:0] rx_lo_ff;
    logic rx_ph_ff;
    logic swp;
    assign swp = (wswap_o == HLM_WSWAP_ON);
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_w_ff <= 32'h00000000;
            rx_lo_ff <= 16'h0000;
            rx_ph_ff <= 1'b0;
        end else begin
            if (tx_word_valid_i && tx_word_ready_o) begin
                tx_w_ff <= tx_word_i;
            end
            if (rx_hw_valid_i) begin
                rx_ph_ff <= !rx_ph_ff;
                if (!rx_ph_ff) begin
                    rx_lo_ff <= rx_hw_i;
                end
            end
        end
    end
    sequence s_tx_take;
        tx_word_valid_i && tx_word_ready_o;
    endsequence
    sequence s_low_sent;
        tx_hw_valid_o && tx_hw_ready_i && tx_hw_o == tx_w_ff[15:0] && tx_hw_o != tx_w_ff[31:16];
    endsequence
    property p_tx_low;
        s_tx_take |=> tx_hw_valid_o && tx_hw_o == tx_w_ff[15:0];
    endproperty
    a_tx_low: assert property (p_tx_low) else $error("first halfword not low");
    property p_tx_high;
        s_low_sent |=> tx_hw_valid_o && tx_hw_o == tx_w_ff[31:16];
    endproperty
    a_tx_high: assert property (p_tx_high) else $error("second halfword not high");
    property p_rx;
        rx_hw_valid_i && rx_ph_ff |=> rx_word_valid_o && rx_word_o == {$past(rx_hw_i), rx_lo_ff};
    endproperty
    a_rx: assert property (p_rx) else $error("receive word packed wrongly");
    property p_wr32;
        int_req_o.wr && !bus16_i && !mixed_endian_i |->
            int_req_o.hw_en == HLM_HW_BOTH && int_req_o.wdata == hdata_i;
    endproperty
    a_wr32: assert property (p_wr32) else $error("wide write lanes wrong");
    property p_wr_mix;
        int_req_o.wr && !bus16_i && mixed_endian_i |->
            int_req_o.wdata == {hdata_i[7:0], hdata_i[15:8], hdata_i[23:16], hdata_i[31:24]};
    endproperty
    a_wr_mix: assert property (p_wr_mix) else $error("mixed endian write wrong");
    property p_wr16_norm;
        int_req_o.wr && bus16_i && !mixed_endian_i && !swp |->
            int_req_o.hw_en == (haddr_i[1] ? HLM_HW_HIGH : HLM_HW_LOW)
            && int_req_o.wdata == {hdata_i[15:0], hdata_i[15:0]};
    endproperty
    a_wr16_norm: assert property (p_wr16_norm) else $error("narrow write lane wrong");
    property p_wr16_swap;
        int_req_o.wr && bus16_i && !mixed_endian_i && swp |->
            int_req_o.hw_en == (haddr_i[1] ? HLM_HW_LOW : HLM_HW_HIGH);
    endproperty
    a_wr16_swap: assert property (p_wr16_swap) else $error("swapped write lane wrong");
    property p_rd32;
        int_req_o.rd && !bus16_i && !mixed_endian_i |->
            ##2 hdata_oe_o && hdata_o == $past(int_rdata_i);
    endproperty
    a_rd32: assert property (p_rd32) else $error("wide read data wrong");
    property p_rd16;
        int_req_o.rd && bus16_i && !mixed_endian_i |-> ##2 hdata_oe_o && hdata_o == {16'h0000,
            (haddr_i[1] ^ swp) ? $past(int_rdata_i[31:16]) : $past(int_rdata_i[15:0])};
    endproperty
    a_rd16: assert property (p_rd16) else $error("narrow read lane wrong");
endmodule : hlm_lane_mapper_properties

/* File: hlm_int_model.sv */
/* Internal register and FIFO word store behind the mapper's internal port.
   Assumes read data is wanted the cycle after a read pulse. */
`timescale 1ns/100ps
module hlm_int_model
    import hlm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Internal port
    input wire hlm_req_type req_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_ff [64];
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h00000000;
            for (int i = 0; i < 64; i++) begin
                mem_ff[i] <= 32'h00000000;
            end
        end else begin
            if (req_i.wr && req_i.hw_en[0]) begin
                mem_ff[req_i.widx][15:0] <= req_i.wdata[15:0];
            end
            if (req_i.wr && req_i.hw_en[1]) begin
                mem_ff[req_i.widx][31:16] <= req_i.wdata[31:16];
            end
            // Outside an answer the lines toggle so stale data never looks valid.
            rdata_o <= req_i.rd ? mem_ff[req_i.widx] : ~rdata_o;
        end
    end
endmodule : hlm_int_model

/* File: hlm_lane_mapper_test.sv */
/* Self-checking testbench for the host halfword lane mapper.
   Assumes hlm_int_model answers the internal port. */
`timescale 1ns/100ps
module hlm_lane_mapper_test;
    import hlm_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cs_b_i = 1'b1, rd_b_i = 1'b1, wr_b_i = 1'b1, bus16_i = 1'b0, mixed_endian_i = 1'b0;
    logic tx_word_valid_i = 1'b0, tx_hw_ready_i = 1'b0, rx_hw_valid_i = 1'b0;
    logic hdata_oe_o, tx_word_ready_o, tx_hw_valid_o, rx_word_valid_o;
    logic [7:1] haddr_i = 7'h00;
    logic [15:0] rx_hw_i = 16'h0000, tx_hw_o;
    logic [31:0] hdata_i = 32'h00000000, tx_word_i = 32'h00000000;
    logic [31:0] hdata_o, wswap_o, int_rdata_i, rx_word_o, rd_v, rx_got, sw;
    hlm_req_type int_req_o;
    logic [15:0] txq[$];
    int errors = 0, tests_run = 0, cyc = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    hlm_lane_mapper u_hlm_lane_mapper (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .cs_b_i(cs_b_i), .rd_b_i(rd_b_i), .wr_b_i(wr_b_i), .bus16_i(bus16_i),
        .haddr_i(haddr_i), .hdata_i(hdata_i), .hdata_o(hdata_o), .hdata_oe_o(hdata_oe_o),
        .mixed_endian_i(mixed_endian_i), .int_req_o(int_req_o), .int_rdata_i(int_rdata_i),
        .tx_word_valid_i(tx_word_valid_i), .tx_word_i(tx_word_i),
        .tx_word_ready_o(tx_word_ready_o), .tx_hw_valid_o(tx_hw_valid_o), .tx_hw_o(tx_hw_o),
        .tx_hw_ready_i(tx_hw_ready_i), .rx_hw_valid_i(rx_hw_valid_i), .rx_hw_i(rx_hw_i),
        .rx_word_valid_o(rx_word_valid_o), .rx_word_o(rx_word_o), .wswap_o(wswap_o));
    hlm_int_model u_hlm_int_model (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .req_i(int_req_o), .rdata_o(int_rdata_i));
    task automatic complete_run;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One host access; pins held well past the answer, then a release gap.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        cs_b_i <= 1'b0;
        rd_b_i <= w;
        wr_b_i <= !w;
        haddr_i <= a[7:1];
        hdata_i <= d;
        repeat (6) @(posedge sys_clk_i);
        rd_v = hdata_o;
        chk({31'h0, hdata_oe_o}, {31'h0, !w});
        cs_b_i <= 1'b1;
        rd_b_i <= 1'b1;
        wr_b_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
    endtask : acc
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (tx_hw_valid_o && tx_hw_ready_i) begin
            txq.push_back(tx_hw_o);
        end
        if (rx_word_valid_o) begin
            rx_got <= rx_word_o;
        end
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(wswap_o, HLM_WSWAP_RST);
        acc(1'b1, 8'h98, HLM_WSWAP_ON);
        acc(1'b1, 8'h10, 32'h12345678);
        acc(1'b0, 8'h10, 32'h00000000);
        chk(rd_v, 32'h12345678);
        acc(1'b0, 8'h98, 32'h00000000);
        chk(rd_v, HLM_WSWAP_ON);
        for (int i = 0; i < 3; i++) begin
            sw = (i == 0) ? 32'h00000000 : ((i == 1) ? 32'hFFFFFFFE : HLM_WSWAP_ON);
            acc(1'b1, 8'h98, sw);
            bus16_i <= 1'b1;
            acc(1'b1, 8'h20, 32'h0000AAAA);
            acc(1'b1, 8'h22, 32'h0000BBBB);
            acc(1'b0, 8'h22, 32'h00000000);
            chk(rd_v, 32'h0000BBBB);
            bus16_i <= 1'b0;
            acc(1'b0, 8'h20, 32'h00000000);
            chk(rd_v, (i == 2) ? 32'hAAAABBBB : 32'hBBBBAAAA);
        end
        mixed_endian_i <= 1'b1;
        acc(1'b1, 8'h30, 32'h11223344);
        mixed_endian_i <= 1'b0;
        acc(1'b0, 8'h30, 32'h00000000);
        chk(rd_v, 32'h44332211);
        mixed_endian_i <= 1'b1;
        acc(1'b0, 8'h30, 32'h00000000);
        mixed_endian_i <= 1'b0;
        chk(rd_v, 32'h11223344);
        tx_word_i <= 32'h89ABCDEF;
        tx_word_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        tx_word_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        tx_hw_ready_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk({txq[0], txq[1]}, 32'hCDEF89AB);
        rx_hw_i <= 16'h1111;
        rx_hw_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_hw_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        rx_hw_i <= 16'h2222;
        rx_hw_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_hw_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk(rx_got, 32'h22221111);
        complete_run();
    end
endmodule : hlm_lane_mapper_test
bind hlm_lane_mapper hlm_lane_mapper_properties u_hlm_lane_mapper_properties (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus16_i(bus16_i), .haddr_i(haddr_i),
    .hdata_i(hdata_i), .hdata_o(hdata_o), .hdata_oe_o(hdata_oe_o),
    .mixed_endian_i(mixed_endian_i), .wswap_o(wswap_o), .int_req_o(int_req_o),
    .int_rdata_i(int_rdata_i), .tx_word_valid_i(tx_word_valid_i), .tx_word_i(tx_word_i),
    .tx_word_ready_o(tx_word_ready_o), .tx_hw_valid_o(tx_hw_valid_o), .tx_hw_o(tx_hw_o),
    .tx_hw_ready_i(tx_hw_ready_i), .rx_hw_valid_i(rx_hw_valid_i), .rx_hw_i(rx_hw_i),
    .rx_word_valid_o(rx_word_valid_o), .rx_word_o(rx_word_o));
